// ---- logic/eewr_regs.vh ----
/*
 * constants of the serial eeprom write path: codes, sizes and timing.
 * assumes inclusion by bare name from the design files of the block.
 */
`ifndef EEWR_REGS_VH
`define EEWR_REGS_VH

`define EEWR_DEV_TYPE      4'hA
`define EEWR_PAGE_BYTES    128
`define EEWR_WORDS_PER_PG  32
`define EEWR_ARRAY_WORDS   16384
`define EEWR_FIFO_DEPTH    32
`define EEWR_FIFO_WIDTH    16
`define EEWR_TWC_NS        5000000
`define EEWR_CLK_NS        10

`endif

// ---- logic/eewr_fifo.v ----
/*
 * eewr_fifo: synchronous first-in first-out buffer, valid/ready both sides.
 * assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none
module eewr_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             sys_clk_i,
    input  wire             rst_i,
    input  wire [WIDTH-1:0] in_data_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    output wire [WIDTH-1:0] out_data_o,
    output wire             out_valid_o,
    input  wire             out_ready_i
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr_ff;
    reg [AW:0]      rd_ptr_ff;
    wire            full;
    wire            empty;
    wire            push;
    wire            pop;

    // pointers carry one extra bit to tell full from empty
    assign full        = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                         (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    assign empty       = (wr_ptr_ff == rd_ptr_ff);
    assign in_ready_o  = ~full;
    assign out_valid_o = ~empty;
    assign out_data_o  = mem[rd_ptr_ff[AW-1:0]];
    assign push        = in_valid_i & ~full;
    assign pop         = out_ready_i & ~empty;

    // storage write
    always @(posedge sys_clk_i) begin
        if (push) begin
            mem[wr_ptr_ff[AW-1:0]] <= in_data_i;
        end
    end

    // pointer update
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            wr_ptr_ff <= {(AW+1){1'b0}};
            rd_ptr_ff <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- logic/eewr_ecc.v ----
/*
 * eewr_ecc: hamming single-error code over 32 data bits with 6 check bits.
 * purely combinational; stored word layout is {check[5:0], data[31:0]}.
 */
`timescale 1ns/10ps
`default_nettype none
module eewr_ecc (
    input  wire [37:0] raw_i,
    input  wire [31:0] wdata_i,
    output reg  [31:0] rdata_o,
    output wire [5:0]  wchk_o
);
    // parity of data bits placed at non-power-of-two code positions
    function [5:0] ecc_par;
        input [31:0] d;
        integer p;
        integer n;
        integer k;
        reg [5:0] acc;
        begin
            acc = 6'h00;
            n = 0;
            for (p = 3; p < 39; p = p + 1) begin
                if ((p & (p - 1)) != 0) begin
                    for (k = 0; k < 6; k = k + 1) begin
                        if (((p >> k) & 1) == 1) begin
                            acc[k] = acc[k] ^ d[n];
                        end
                    end
                    n = n + 1;
                end
            end
            ecc_par = acc;
        end
    endfunction

    assign wchk_o = ecc_par(wdata_i);

    // syndrome names the failing code position; flip that data bit
    always @* begin : corr
        reg [5:0] syn;
        integer p;
        integer n;
        n = 0;
        p = 0;
        syn = raw_i[37:32] ^ ecc_par(raw_i[31:0]);
        rdata_o = raw_i[31:0];
        for (p = 3; p < 39; p = p + 1) begin
            if ((p & (p - 1)) != 0) begin
                if (syn == p[5:0]) begin
                    rdata_o[n] = ~raw_i[n];
                end
                n = n + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- logic/eewr_top.v ----
/*
 * eewr_top: two-wire slave write path of a serial eeprom with ecc array,
 * page latch and self-timed program cycle.
 * assumes scl/sda and the strap pins arrive asynchronously; the bus wire
 * is resolved outside from sda_o/sda_oe_o (open drain, low when enabled).
 */
`timescale 1ns/10ps
`default_nettype none
`include "eewr_regs.vh"
module eewr_top #(
    parameter TWC_CYCLES = `EEWR_TWC_NS / `EEWR_CLK_NS
) (
    input  wire sys_clk_i,
    input  wire rst_i,
    input  wire scl_i,
    input  wire sda_i,
    output wire sda_o,
    output wire sda_oe_o,
    input  wire hw_addr_bit2_i,
    input  wire hw_addr_bit1_i,
    input  wire hw_addr_bit0_i,
    input  wire wp_i,
    output wire busy_o,
    output wire standby_o
);
    // serial phases
    localparam PH_IDLE = 3'd0;
    localparam PH_DEV  = 3'd1;
    localparam PH_WHI  = 3'd2;
    localparam PH_WLO  = 3'd3;
    localparam PH_DATA = 3'd4;
    // commit states
    localparam C_IDLE  = 3'd0;
    localparam C_DRAIN = 3'd1;
    localparam C_SCAN  = 3'd2;
    localparam C_WR    = 3'd3;
    localparam C_TIME  = 3'd4;

    // pin synchronisers
    reg        scl_meta_ff;
    reg        scl_s_ff;
    reg        scl_d_ff;
    reg        sda_meta_ff;
    reg        sda_s_ff;
    reg        sda_d_ff;
    reg [3:0]  pin_meta_ff;
    reg [3:0]  pin_s_ff;
    // serial machine
    reg [2:0]  phase_ff;
    reg [3:0]  bit_cnt_ff;
    reg [7:0]  shift_ff;
    reg        ack_phase_ff;
    reg        sda_oe_ff;
    reg        first_ff;
    reg        have_data_ff;
    reg [8:0]  page_ff;
    reg [6:0]  off_ff;
    reg        launch_ff;
    reg        standby_ff;
    // commit side
    reg [2:0]  cstate_ff;
    reg [2:0]  nxt_cstate;
    reg [4:0]  widx_ff;
    reg [19:0] timer_ff;
    reg        busy_ff;
    reg [37:0] rd_word_ff;
    reg [127:0] valid_ff;
    reg [127:0] nxt_valid;
    reg [7:0]  latch [0:`EEWR_PAGE_BYTES-1];
    reg [37:0] array [0:`EEWR_ARRAY_WORDS-1];
    reg [31:0] merged;
    integer    b;

    wire       scl_rise;
    wire       scl_fall;
    wire       start_det;
    wire       stop_det;
    wire [7:0] byte_in;
    wire       dev_match;
    wire       fifo_in_valid;
    wire       fifo_in_ready;
    wire [15:0] fifo_in_data;
    wire [15:0] fifo_out_data;
    wire       fifo_out_valid;
    wire       fifo_out_ready;
    wire [31:0] corr_data;
    wire [5:0] new_chk;
    wire [13:0] word_addr;
    wire [3:0] word_valid;

    // two-flop synchronisers, third stage for edge finding
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            scl_meta_ff <= 1'b1;
            scl_s_ff    <= 1'b1;
            scl_d_ff    <= 1'b1;
            sda_meta_ff <= 1'b1;
            sda_s_ff    <= 1'b1;
            sda_d_ff    <= 1'b1;
            pin_meta_ff <= 4'h0;
            pin_s_ff    <= 4'h0;
        end else begin
            scl_meta_ff <= scl_i;
            scl_s_ff    <= scl_meta_ff;
            scl_d_ff    <= scl_s_ff;
            sda_meta_ff <= sda_i;
            sda_s_ff    <= sda_meta_ff;
            sda_d_ff    <= sda_s_ff;
            pin_meta_ff <= {wp_i, hw_addr_bit2_i, hw_addr_bit1_i,
                            hw_addr_bit0_i};
            pin_s_ff    <= pin_meta_ff;
        end
    end

    // bus conditions
    assign scl_rise  = scl_s_ff & ~scl_d_ff;
    assign scl_fall  = ~scl_s_ff & scl_d_ff;
    assign start_det = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
    assign stop_det  = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;
    assign byte_in   = shift_ff;

    // write-direction address with matching type and straps, not busy
    assign dev_match = (byte_in[7:4] == `EEWR_DEV_TYPE) &&
                       (byte_in[3:1] == pin_s_ff[2:0]) &&
                       ~byte_in[0] && ~busy_ff;

    // data bytes go to the buffer with their page offset
    assign fifo_in_data  = {first_ff, off_ff, byte_in};
    assign fifo_in_valid = scl_fall & ~ack_phase_ff &
                           (bit_cnt_ff == 4'd8) & (phase_ff == PH_DATA);

    // serial machine: sample on rise, act on fall
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            phase_ff     <= PH_IDLE;
            bit_cnt_ff   <= 4'h0;
            shift_ff     <= 8'h00;
            ack_phase_ff <= 1'b0;
            sda_oe_ff    <= 1'b0;
            first_ff     <= 1'b0;
            have_data_ff <= 1'b0;
            page_ff      <= 9'h000;
            off_ff       <= 7'h00;
            launch_ff    <= 1'b0;
        end else begin
            launch_ff <= 1'b0;
            if (start_det) begin
                // fresh protocol; an open write is abandoned
                phase_ff     <= PH_DEV;
                bit_cnt_ff   <= 4'h0;
                ack_phase_ff <= 1'b0;
                sda_oe_ff    <= 1'b0;
                have_data_ff <= 1'b0;
            end else if (stop_det) begin
                phase_ff     <= PH_IDLE;
                ack_phase_ff <= 1'b0;
                sda_oe_ff    <= 1'b0;
                have_data_ff <= 1'b0;
                // protected target: no program cycle at all
                if (phase_ff == PH_DATA && have_data_ff && ~busy_ff &&
                    ~pin_s_ff[3]) begin
                    launch_ff <= 1'b1;
                end
            end else if (scl_rise) begin
                if (bit_cnt_ff < 4'd8 && ~ack_phase_ff) begin
                    shift_ff   <= {shift_ff[6:0], sda_s_ff};
                    bit_cnt_ff <= bit_cnt_ff + 4'd1;
                end
            end else if (scl_fall) begin
                if (ack_phase_ff) begin
                    // ninth clock over: let go of the line
                    ack_phase_ff <= 1'b0;
                    sda_oe_ff    <= 1'b0;
                    bit_cnt_ff   <= 4'h0;
                end else if (bit_cnt_ff == 4'd8) begin
                    ack_phase_ff <= 1'b1;
                    case (phase_ff)
                        PH_DEV: begin
                            if (dev_match) begin
                                sda_oe_ff <= 1'b1;
                                phase_ff  <= PH_WHI;
                                first_ff  <= 1'b1;
                            end else begin
                                phase_ff  <= PH_IDLE;
                            end
                        end
                        PH_WHI: begin
                            sda_oe_ff    <= 1'b1;
                            page_ff[8:1] <= byte_in;
                            phase_ff     <= PH_WLO;
                        end
                        PH_WLO: begin
                            sda_oe_ff  <= 1'b1;
                            page_ff[0] <= byte_in[7];
                            off_ff     <= byte_in[6:0];
                            phase_ff   <= PH_DATA;
                        end
                        PH_DATA: begin
                            if (fifo_in_ready) begin
                                sda_oe_ff    <= 1'b1;
                                off_ff       <= off_ff + 7'd1;
                                first_ff     <= 1'b0;
                                have_data_ff <= 1'b1;
                            end else begin
                                phase_ff <= PH_IDLE;
                            end
                        end
                        default: begin
                            sda_oe_ff <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    // byte buffer between the serial side and the page latch
    eewr_fifo #(
        .WIDTH (`EEWR_FIFO_WIDTH),
        .DEPTH (`EEWR_FIFO_DEPTH),
        .AW    (5)
    ) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .in_data_i   (fifo_in_data),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .out_data_o  (fifo_out_data),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_out_ready)
    );

    // latch is frozen while words are being committed
    assign fifo_out_ready = (cstate_ff == C_IDLE) ||
                            (cstate_ff == C_DRAIN);

    // page latch fill; first byte of a write drops older flags
    always @* begin
        nxt_valid = valid_ff;
        if (fifo_out_valid && fifo_out_ready) begin
            if (fifo_out_data[15]) begin
                nxt_valid = {128{1'b0}};
            end
            nxt_valid[fifo_out_data[14:8]] = 1'b1;
        end
    end

    always @(posedge sys_clk_i) begin
        if (fifo_out_valid && fifo_out_ready) begin
            latch[fifo_out_data[14:8]] <= fifo_out_data[7:0];
        end
    end

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            valid_ff <= {128{1'b0}};
        end else begin
            valid_ff <= nxt_valid;
        end
    end

    // word selection for read-modify-write
    assign word_addr  = {page_ff, widx_ff};
    assign word_valid = valid_ff[{widx_ff, 2'b00} +: 4];

    eewr_ecc u_ecc (
        .raw_i   (rd_word_ff),
        .wdata_i (merged),
        .rdata_o (corr_data),
        .wchk_o  (new_chk)
    );

    // keep corrected old bytes where no new byte was given
    always @* begin
        merged = corr_data;
        for (b = 0; b < 4; b = b + 1) begin
            if (word_valid[b]) begin
                merged[b*8 +: 8] = latch[{widx_ff, b[1:0]}];
            end
        end
    end

    // commit sequencer next state
    always @* begin
        nxt_cstate = cstate_ff;
        case (cstate_ff)
            C_IDLE: begin
                if (launch_ff) begin
                    nxt_cstate = C_DRAIN;
                end
            end
            C_DRAIN: begin
                if (~fifo_out_valid) begin
                    nxt_cstate = C_SCAN;
                end
            end
            C_SCAN: begin
                if (|word_valid) begin
                    nxt_cstate = C_WR;
                end else if (widx_ff == 5'd31) begin
                    nxt_cstate = C_TIME;
                end
            end
            C_WR: begin
                if (widx_ff == 5'd31) begin
                    nxt_cstate = C_TIME;
                end else begin
                    nxt_cstate = C_SCAN;
                end
            end
            C_TIME: begin
                if (timer_ff == TWC_CYCLES - 1) begin
                    nxt_cstate = C_IDLE;
                end
            end
            default: begin
                nxt_cstate = C_IDLE;
            end
        endcase
    end

    // commit sequencer registers; untouched by bus recovery
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            cstate_ff  <= C_IDLE;
            widx_ff    <= 5'h00;
            timer_ff   <= 20'h00000;
            busy_ff    <= 1'b0;
            rd_word_ff <= 38'h0;
        end else begin
            cstate_ff <= nxt_cstate;
            busy_ff   <= (nxt_cstate != C_IDLE);
            if (cstate_ff == C_DRAIN) begin
                widx_ff <= 5'h00;
            end else if (cstate_ff == C_SCAN) begin
                if (|word_valid) begin
                    rd_word_ff <= array[word_addr];
                end else if (widx_ff != 5'd31) begin
                    widx_ff <= widx_ff + 5'd1;
                end
            end else if (cstate_ff == C_WR && widx_ff != 5'd31) begin
                widx_ff <= widx_ff + 5'd1;
            end
            if (cstate_ff == C_TIME) begin
                timer_ff <= timer_ff + 20'd1;
            end else begin
                timer_ff <= 20'h00000;
            end
        end
    end

    // array write of the whole word with fresh check bits
    always @(posedge sys_clk_i) begin
        if (cstate_ff == C_WR) begin
            array[word_addr] <= {new_chk, merged};
        end
    end

    // standby whenever neither serial nor program activity is open
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            standby_ff <= 1'b1;
        end else begin
            // launch and next commit state keep standby off once busy rises
            standby_ff <= (phase_ff == PH_IDLE) && ~launch_ff &&
                          (nxt_cstate == C_IDLE);
        end
    end

    assign sda_o     = 1'b0;
    assign sda_oe_o  = sda_oe_ff;
    assign busy_o    = busy_ff;
    assign standby_o = standby_ff;
endmodule
`default_nettype wire

// ---- dv/eewr_asserts.sv ----
/* eewr_asserts: port-level checker of the eeprom write path.
   assumes bind onto eewr_top and a bus left idle high between frames. */
`timescale 1ns/10ps
`default_nettype none
module eewr_asserts #(
    parameter TWC_CYCLES = 50
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic hw_addr_bit2_i,
    input wire logic hw_addr_bit1_i,
    input wire logic hw_addr_bit0_i,
    input wire logic wp_i,
    input wire logic busy_o,
    input wire logic standby_o
);
    logic [31:0] busy_cnt_ff;

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // cycles spent in the current program cycle
    always @(posedge sys_clk_i) begin
        if (rst_i || !busy_o)
            busy_cnt_ff <= 32'h0;
        else
            busy_cnt_ff <= busy_cnt_ff + 32'h1;
    end

    AST_RST_STATE: assert property (disable iff (1'b0)
        rst_i |=> !sda_oe_o && !busy_o && standby_o)
        else $error("outputs wrong after reset");
    AST_ACK_CLK_LOW: assert property ($rose(sda_oe_o) |-> !scl_i)
        else $error("ack driven while clock high");
    AST_ACK_STABLE: assert property (sda_oe_o && $rose(scl_i)
        |=> sda_oe_o [*3])
        else $error("ack dropped in clock high phase");
    AST_BUSY_DEAF: assert property (busy_o |-> !$rose(sda_oe_o))
        else $error("ack given while busy");
    AST_BUSY_AWAKE: assert property (busy_o |-> !standby_o)
        else $error("standby during program cycle");
    AST_ACK_AWAKE: assert property (sda_oe_o |-> !standby_o)
        else $error("standby while acknowledging");
    AST_TWC_LEN: assert property ($fell(busy_o) |->
        busy_cnt_ff >= TWC_CYCLES && busy_cnt_ff <= TWC_CYCLES + 300)
        else $error("program cycle length wrong");
    AST_BUSY_AT_STOP: assert property ($rose(busy_o) |->
        scl_i && sda_i && !$past(wp_i, 4))
        else $error("program cycle without stop or under protect");
    AST_ACK_RELEASE: assert property ($rose(sda_oe_o) |->
        ##[1:300] !sda_oe_o)
        else $error("data line held too long");

    // main scenarios reached
    cover property ($rose(busy_o));
    cover property ($fell(busy_o));
    cover property ($rose(sda_oe_o));
endmodule
`default_nettype wire

// ---- dv/eewr_master.sv ----
/* eewr_master: behavioural two-wire bus master, open drain data output.
   assumes the bench resolves the wire with a pull-up; clock idles high. */
`timescale 1ns/10ps
`default_nettype none
module eewr_master (
    output var logic scl_o,
    output var logic sda_o,
    input  wire logic sda_i
);
    localparam realtime QTR = 31.25;

    // bus idle between frames
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // data falls while clock high opens a frame
    task automatic start();
        sda_o = 1'b1;
        #QTR;
        scl_o = 1'b1;
        #(2*QTR);
        sda_o = 1'b0;
        #(2*QTR);
        scl_o = 1'b0;
        #QTR;
    endtask

    // data rises while clock high closes a frame
    task automatic stop();
        sda_o = 1'b0;
        #QTR;
        scl_o = 1'b1;
        #(2*QTR);
        sda_o = 1'b1;
        #(4*QTR);
    endtask

    // msb first, data moved only with clock low
    task automatic bits(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            sda_o = b[i];
            #QTR;
            scl_o = 1'b1;
            #(2*QTR);
            scl_o = 1'b0;
            #QTR;
        end
    endtask

    // byte plus ninth clock carrying the acknowledge
    task automatic wbyte(input logic [7:0] b, output logic ack);
        bits(b, 8);
        sda_o = 1'b1;
        #QTR;
        scl_o = 1'b1;
        #QTR;
        ack = !sda_i;
        #QTR;
        scl_o = 1'b0;
        #QTR;
    endtask

    // recovery: clock until the device lets the line go
    task automatic dummy(output int n);
        n = 0;
        sda_o = 1'b1;
        #QTR;
        while (!sda_i && n < 16) begin
            scl_o = 1'b1;
            #(2*QTR);
            scl_o = 1'b0;
            #(2*QTR);
            n++;
        end
    endtask
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
/* tb: self-checking bench of the eeprom write path with a bus master.
   assumes the checker is bound below and the strap pins stay fixed. */
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int TWC = 300;
    localparam logic [2:0] STRAP = 3'h5;
    localparam logic [7:0] DEV = {4'hA, STRAP, 1'b0};
    logic clk = 1'b0;
    logic rst;
    logic wp;
    wire  scl;
    wire  m_sda;
    wire  sda_w;
    wire  sda_oe;
    wire  dev_sda;
    wire  busy;
    wire  stby;
    int   n_errors = 0;
    int   samples_checked = 0;

    always #5 clk = ~clk;
    // open drain wire with pull-up
    assign sda_w = m_sda & ~(sda_oe & ~dev_sda);

    eewr_master partner (.scl_o(scl), .sda_o(m_sda), .sda_i(sda_w));
    eewr_top #(.TWC_CYCLES(TWC)) uut (
        .sys_clk_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(sda_w),
        .sda_o(dev_sda), .sda_oe_o(sda_oe), .hw_addr_bit2_i(STRAP[2]),
        .hw_addr_bit1_i(STRAP[1]), .hw_addr_bit0_i(STRAP[0]),
        .wp_i(wp), .busy_o(busy), .standby_o(stby));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // full write frame, every byte acknowledged
    task automatic wr(input logic [15:0] wa, input int nd);
        logic ak;
        partner.start();
        partner.wbyte(DEV, ak);
        check(ak, 1'b1);
        partner.wbyte(wa[15:8], ak);
        check(ak, 1'b1);
        partner.wbyte(wa[7:0], ak);
        check(ak, 1'b1);
        for (int i = 0; i < nd; i++) begin
            partner.wbyte(8'h5A ^ i[7:0], ak);
            check(ak, 1'b1);
        end
        partner.stop();
    endtask

    task automatic poll(input logic [7:0] a, input logic exp);
        logic ak;
        partner.start();
        partner.wbyte(a, ak);
        check(ak, exp);
        partner.stop();
    endtask

    // bounded wait for the program cycle to end
    task automatic wait_idle();
        for (int i = 0; i < 2000 && busy !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        check(busy, 1'b0);
        check(stby, 1'b1);
    endtask

    task automatic t_byte();
        wr(16'h1234, 1);
        check(busy, 1'b1);
        check(stby, 1'b0);
        poll(DEV, 1'b0);
        wait_idle();
        check(uut.array[14'h048D][7:0], 8'h5A);
        poll(DEV, 1'b1);
    endtask

    task automatic t_refuse();
        logic [7:0] bad [3];
        bad = '{{4'hA, ~STRAP, 1'b0}, DEV | 8'h01, {4'hB, STRAP, 1'b0}};
        foreach (bad[i]) begin
            poll(bad[i], 1'b0);
            check(busy, 1'b0);
            check(stby, 1'b1);
        end
    endtask

    task automatic t_wp();
        @(posedge clk);
        #1 wp = 1'b1;
        wr(16'h0040, 2);
        check(busy, 1'b0);
        poll(DEV, 1'b1);
        @(posedge clk);
        #1 wp = 1'b0;
    endtask

    // page start near its end, 130 bytes wrap inside the page
    task automatic t_page();
        wr(16'hABF0, 130);
        check(busy, 1'b1);
        wait_idle();
        check(uut.array[14'h2AFC][31:0], 32'h5958DBDA);
    endtask

    task automatic t_recover();
        int n;
        partner.start();
        partner.bits(DEV, 8);
        partner.dummy(n);
        check(n >= 1 && n <= 9, 1'b1);
        check(sda_w, 1'b1);
        wr(16'h2003, 1);
        partner.start();
        partner.bits(8'hFF, 5);
        partner.dummy(n);
        check(busy, 1'b1);
        partner.stop();
        wait_idle();
        check(uut.array[14'h0800][31:24], 8'h5A);
        poll(DEV, 1'b1);
    endtask

    initial begin
        rst = 1'b1;
        wp = 1'b0;
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        check(sda_oe, 1'b0);
        check(stby, 1'b1);
        t_byte();
        t_refuse();
        t_wp();
        t_page();
        t_recover();
        print_verdict();
    end

    // watchdog well beyond the expected run
    initial begin
        #600000;
        n_errors++;
        print_verdict();
    end
endmodule

bind eewr_top eewr_asserts #(.TWC_CYCLES(TWC_CYCLES)) chk (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .hw_addr_bit2_i(hw_addr_bit2_i), .hw_addr_bit1_i(hw_addr_bit1_i),
    .hw_addr_bit0_i(hw_addr_bit0_i), .wp_i(wp_i), .busy_o(busy_o),
    .standby_o(standby_o));
`default_nettype wire
